// ==== include/lte_params.svh ====
/*
 * Constants of the limit trigger engine: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 200 MHz pclk and an APB master with 32-bit data.
 */
//
// Operation
// - threshold trigger trips when input is equal to or above trip level
// - basic trigger latches until an explicit clear request
// - disable setting 0 lets trigger run, 1 stops it tripping
// - boolean and standalone triggers trip on a 1/0 bit and latch
// - hysteresis trip waits trip qualification time; zero trips at once
// - non-latching trigger clears after clear qualification time; zero at once
// - latching select 1 holds trip until clear, 0 self-clears
// - user triggers act like hysteresis, never warn, fault or open contactors; the code takes their kind from the kind field
// - user trigger states route to general output and a readable point
// - fault trip gives graceful disconnect, inverter off, optional reconnect
// - over/under fault disconnects fast and locks out until user clears
// - external fault and warning triggers fed from the two general inputs
// - active warning requests current derating without disconnecting
`ifndef LTE_PARAMS_SVH
`define LTE_PARAMS_SVH

`define LTE_NTRIG 8
`define LTE_CLK_NS 5
`define LTE_TICK_NS 1000
`define LTE_TICK_CYC (`LTE_TICK_NS / `LTE_CLK_NS)

// register byte addresses
`define LTE_A_CTRL 12'h000
`define LTE_A_CLEAR 12'h004
`define LTE_A_STATE 12'h008
`define LTE_A_IRQ_STS 12'h00C
`define LTE_A_IRQ_MASK 12'h010
`define LTE_A_EXT 12'h014
`define LTE_A_GPO_MASK 12'h018
`define LTE_A_USER 12'h01C
`define LTE_A_TRIG 12'h080
`define LTE_TRIG_STRIDE 12'h010
`define LTE_F_CFG 2'h0
`define LTE_F_THR 2'h1
`define LTE_F_TQ 2'h2
`define LTE_F_CQ 2'h3

// field positions
`define LTE_CTRL_RECON 0
`define LTE_CLR_LOCK 8
`define LTE_ST_GRACE 8
`define LTE_ST_FAST 9
`define LTE_ST_WARN 10
`define LTE_EXT_FFLAG 0
`define LTE_EXT_WFLAG 1
`define LTE_EXT_FEN 4
`define LTE_EXT_FSEL 5
`define LTE_EXT_WEN 6
`define LTE_EXT_WSEL 7
`define LTE_SLOT_XFAULT 6
`define LTE_SLOT_XWARN 7

// reset values
`define LTE_CFG_RST 8'h01
`define LTE_THR_RST 16'hFFFF
`define LTE_Q_RST 16'h0000

`endif

// ==== include/lte_pkg.sv ====
/*
 * Types of the limit trigger engine.
 * Takes nothing from lte_params.svh; encodings and widths are written here.
 */
package lte_pkg;

    typedef enum logic [1:0] {
        LTE_KIND_BASIC = 2'b00,
        LTE_KIND_BOOL = 2'b01,
        LTE_KIND_ALONE = 2'b10,
        LTE_KIND_HYST = 2'b11
    } lte_kind_t;

    typedef enum logic [1:0] {
        LTE_LVL_WARN = 2'b00,
        LTE_LVL_GRACE = 2'b01,
        LTE_LVL_HARD = 2'b10,
        LTE_LVL_USER = 2'b11
    } lte_lvl_t;

    typedef enum logic [1:0] {
        LTE_ST_IDLE = 2'b00,
        LTE_ST_QTRIP = 2'b01,
        LTE_ST_TRIP = 2'b10,
        LTE_ST_QCLR = 2'b11
    } lte_tst_t;

    typedef struct packed {
        lte_lvl_t level;
        lte_kind_t kind;
        logic pol;
        logic use_bit;
        logic latched;
        logic disabled;
    } lte_cfg_t;

    typedef logic [7:0][15:0] lte_meas_t;

endpackage : lte_pkg

// ==== src/lte_trig.sv ====
/*
 * One trigger: qualification timers, latching and clear handling.
 * Assumes a one-cycle tick pulse and synchronous inputs.
 */
`timescale 1ns/10ps
`include "lte_params.svh"
module lte_trig (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // control
    input wire logic tick,
    input wire logic cond,
    input wire logic dis,
    input wire logic latch,
    input wire logic clr,
    input wire logic [15:0] tq,
    input wire logic [15:0] cq,
    // status
    output logic tripped
);
    import lte_pkg::*;

    lte_tst_t st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic trip_r, trip_nxt;
    logic [15:0] cnt_inc;

    assign cnt_inc = cnt_r + 16'h0001;
    assign tripped = trip_r;

    // ******************************
    // state machine
    // ******************************
    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        trip_nxt = trip_r;
        case (st_r)
            LTE_ST_IDLE:
                if (!dis && cond)
                begin
                    cnt_nxt = 16'h0000;
                    if (tq == 16'h0000)
                    begin
                        st_nxt = LTE_ST_TRIP;
                        trip_nxt = 1'b1;
                    end
                    else
                        st_nxt = LTE_ST_QTRIP;
                end
            LTE_ST_QTRIP:
                if (dis || !cond)
                begin
                    st_nxt = LTE_ST_IDLE;
                    cnt_nxt = 16'h0000;
                end
                else if (tick)
                begin
                    cnt_nxt = cnt_inc;
                    if (cnt_inc >= tq)
                    begin
                        st_nxt = LTE_ST_TRIP;
                        trip_nxt = 1'b1;
                    end
                end
            LTE_ST_TRIP:
                if (dis || clr)
                begin
                    st_nxt = LTE_ST_IDLE;
                    trip_nxt = 1'b0;
                end
                else if (!latch && !cond)
                begin
                    cnt_nxt = 16'h0000;
                    if (cq == 16'h0000)
                    begin
                        st_nxt = LTE_ST_IDLE;
                        trip_nxt = 1'b0;
                    end
                    else
                        st_nxt = LTE_ST_QCLR;
                end
            LTE_ST_QCLR:
                if (dis || clr)
                begin
                    st_nxt = LTE_ST_IDLE;
                    trip_nxt = 1'b0;
                end
                else if (cond || latch)
                begin
                    st_nxt = LTE_ST_TRIP;
                    cnt_nxt = 16'h0000;
                end
                else if (tick)
                begin
                    cnt_nxt = cnt_inc;
                    if (cnt_inc >= cq)
                    begin
                        st_nxt = LTE_ST_IDLE;
                        trip_nxt = 1'b0;
                    end
                end
            default:
            begin
                st_nxt = LTE_ST_IDLE;
                trip_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= LTE_ST_IDLE;
            cnt_r <= 16'h0000;
            trip_r <= 1'b0;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            trip_r <= trip_nxt;
        end
    end

    // ******************************
    // checks
    // ******************************
    AST_IMM_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st_r == LTE_ST_IDLE && !dis && cond && tq == 16'h0000)
        |=> trip_r)
        else $error("trigger did not trip at once with zero time");
    AST_DIS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && dis) |=> !trip_r)
        else $error("disabled trigger is tripped");
    AST_LATCH_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && trip_r && latch && !dis && !clr) |=> trip_r)
        else $error("latched trigger cleared without request");
    AST_QUAL_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st_r == LTE_ST_QTRIP && !cond) |=> st_r == LTE_ST_IDLE
        && cnt_r == 16'h0000 && !trip_r)
        else $error("trip qualification not restarted");
    AST_IMM_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && st_r == LTE_ST_TRIP && !latch && !cond && cq == 16'h0000)
        |=> !trip_r)
        else $error("self-clearing trigger did not clear at once");

endmodule : lte_trig

// ==== src/lte_top.sv ====
/*
 * Limit trigger engine: eight configurable triggers, APB registers,
 * protection outputs and interrupt.
 * Assumes synchronous inputs on pclk at 200 MHz and an APB master.
 */
`timescale 1ns/10ps
`include "lte_params.svh"
module lte_top (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurements
    input wire lte_pkg::lte_meas_t meas,
    input wire logic [7:0] bits,
    input wire logic [1:0] gpi,
    // protection and notification
    output logic [7:0] trip,
    output logic disc_graceful,
    output logic disc_fast,
    output logic inverter_off,
    output logic derate,
    output logic gpo,
    output logic irq
);
    import lte_pkg::*;

    // ******************************
    // register state
    // ******************************
    logic recon_r, recon_nxt;
    logic [7:0] ext_r, ext_nxt;
    logic [7:0] gmask_r, gmask_nxt;
    logic [7:0] imask_r, imask_nxt;
    logic [7:0] ists_r, ists_nxt;
    lte_cfg_t cfg_r [`LTE_NTRIG];
    lte_cfg_t cfg_nxt [`LTE_NTRIG];
    logic [15:0] thr_r [`LTE_NTRIG];
    logic [15:0] thr_nxt [`LTE_NTRIG];
    logic [15:0] tq_r [`LTE_NTRIG];
    logic [15:0] tq_nxt [`LTE_NTRIG];
    logic [15:0] cq_r [`LTE_NTRIG];
    logic [15:0] cq_nxt [`LTE_NTRIG];
    logic [31:0] rdata_r, rdata_nxt;
    logic rdy_r, rdy_nxt;
    logic err_r, err_nxt;
    logic [7:0] clr_r, clr_nxt;
    logic lock_clr_r, lock_clr_nxt;

    // protection state
    logic [7:0] tpulse, tripw, trip_d_r;
    logic grace_r, grace_nxt;
    logic fast_r, fast_nxt;
    logic inv_r, inv_nxt;
    logic warn_r, warn_nxt;
    logic gpo_r, gpo_nxt;
    logic irq_r, irq_nxt;
    logic [7:0] tick_cnt_r, tick_cnt_nxt;
    logic tick_r, tick_nxt;

    // decoded access
    logic acc, wr_ok, rd_ok, trig_hit;
    logic [2:0] tidx;
    logic [1:0] tfld;
    logic [7:0] user_v, hard_v, grace_v, warn_v;
    logic ext_fault, ext_warn;

    assign acc = psel && penable && rdy_r;
    assign wr_ok = acc && pwrite && !err_r;
    assign rd_ok = acc && !pwrite;
    assign trig_hit = (paddr[11:7] == `LTE_A_TRIG >> 7);
    assign tidx = paddr[6:4];
    assign tfld = paddr[3:2];

    // ******************************
    // external flags
    // ******************************
    // a routed input overrides the software flag; unrouted, software
    // writes the flag itself
    assign ext_fault = ext_r[`LTE_EXT_FEN] ? gpi[ext_r[`LTE_EXT_FSEL]]
                                           : ext_r[`LTE_EXT_FFLAG];
    assign ext_warn = ext_r[`LTE_EXT_WEN] ? gpi[ext_r[`LTE_EXT_WSEL]]
                                          : ext_r[`LTE_EXT_WFLAG];

    // ******************************
    // triggers
    // ******************************
    genvar g;
    generate
        for (g = 0; g < `LTE_NTRIG; g = g + 1)
        begin : gen_trig
            logic bsrc, cond, latch_eff;
            logic hyst;
            logic [15:0] tq_eff;
            lte_cfg_t c;
            assign c = cfg_r[g];
            assign hyst = (c.kind == LTE_KIND_HYST);
            if (g == `LTE_SLOT_XFAULT)
            begin : gen_xf
                assign bsrc = ext_fault;
            end
            else if (g == `LTE_SLOT_XWARN)
            begin : gen_xw
                assign bsrc = ext_warn;
            end
            else
            begin : gen_bit
                assign bsrc = bits[g];
            end
            assign cond = (c.use_bit || c.kind == LTE_KIND_BOOL
                           || c.kind == LTE_KIND_ALONE)
                          ? (bsrc == c.pol)
                          : (meas[g] >= thr_r[g]);
            assign latch_eff = !hyst || c.latched;
            assign tq_eff = hyst ? tq_r[g] : 16'h0000;
            assign user_v[g] = tripw[g] && c.level == LTE_LVL_USER;
            assign hard_v[g] = tripw[g] && c.level == LTE_LVL_HARD;
            assign grace_v[g] = tripw[g] && c.level == LTE_LVL_GRACE;
            assign warn_v[g] = tripw[g] && c.level == LTE_LVL_WARN;
            lte_trig u_trig (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .tick(tick_r),
                .cond(cond),
                .dis(c.disabled),
                .latch(latch_eff),
                .clr(clr_r[g]),
                .tq(tq_eff),
                .cq(cq_r[g]),
                .tripped(tripw[g])
            );
        end
    endgenerate

    assign tpulse = tripw & ~trip_d_r;

    // ******************************
    // apb registers
    // ******************************
    always_comb
    begin
        recon_nxt = recon_r;
        ext_nxt = ext_r;
        gmask_nxt = gmask_r;
        imask_nxt = imask_r;
        cfg_nxt = cfg_r;
        thr_nxt = thr_r;
        tq_nxt = tq_r;
        cq_nxt = cq_r;
        clr_nxt = 8'h00;
        lock_clr_nxt = 1'b0;
        rdata_nxt = rdata_r;
        err_nxt = 1'b0;
        rdy_nxt = psel && penable && !rdy_r;
        // trip events win over a read clear in the same cycle
        ists_nxt = (rd_ok && paddr == `LTE_A_IRQ_STS)
                   ? tpulse : (ists_r | tpulse);
        if (psel && penable && !rdy_r)
        begin
            rdata_nxt = 32'h0000_0000;
            if (trig_hit)
                case (tfld)
                    `LTE_F_CFG: rdata_nxt[7:0] = cfg_r[tidx];
                    `LTE_F_THR: rdata_nxt[15:0] = thr_r[tidx];
                    `LTE_F_TQ: rdata_nxt[15:0] = tq_r[tidx];
                    `LTE_F_CQ: rdata_nxt[15:0] = cq_r[tidx];
                    default: rdata_nxt = 32'h0000_0000;
                endcase
            else
                case (paddr)
                    `LTE_A_CTRL: rdata_nxt[`LTE_CTRL_RECON] = recon_r;
                    `LTE_A_CLEAR: rdata_nxt = 32'h0000_0000;
                    `LTE_A_STATE:
                        rdata_nxt[10:0] = {warn_r, fast_r, grace_r, tripw};
                    `LTE_A_IRQ_STS: rdata_nxt[7:0] = ists_r | tpulse;
                    `LTE_A_IRQ_MASK: rdata_nxt[7:0] = imask_r;
                    `LTE_A_EXT: rdata_nxt[7:0] = ext_r;
                    `LTE_A_GPO_MASK: rdata_nxt[7:0] = gmask_r;
                    `LTE_A_USER: rdata_nxt[7:0] = user_v;
                    default: err_nxt = 1'b1;
                endcase
        end
        else
            err_nxt = err_r && !acc;
        if (wr_ok)
        begin
            if (trig_hit)
                case (tfld)
                    `LTE_F_CFG: cfg_nxt[tidx] = lte_cfg_t'(pwdata[7:0]);
                    `LTE_F_THR: thr_nxt[tidx] = pwdata[15:0];
                    `LTE_F_TQ: tq_nxt[tidx] = pwdata[15:0];
                    `LTE_F_CQ: cq_nxt[tidx] = pwdata[15:0];
                    default: cq_nxt[tidx] = cq_r[tidx];
                endcase
            else
                case (paddr)
                    `LTE_A_CTRL: recon_nxt = pwdata[`LTE_CTRL_RECON];
                    `LTE_A_CLEAR:
                    begin
                        clr_nxt = pwdata[7:0];
                        lock_clr_nxt = pwdata[`LTE_CLR_LOCK];
                    end
                    `LTE_A_IRQ_MASK: imask_nxt = pwdata[7:0];
                    `LTE_A_EXT: ext_nxt = pwdata[7:0];
                    `LTE_A_GPO_MASK: gmask_nxt = pwdata[7:0];
                    default: ext_nxt = ext_r;
                endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            recon_r <= 1'b0;
            ext_r <= 8'h00;
            gmask_r <= 8'h00;
            imask_r <= 8'h00;
            ists_r <= 8'h00;
            for (int i = 0; i < `LTE_NTRIG; i++)
            begin
                cfg_r[i] <= lte_cfg_t'(`LTE_CFG_RST);
                thr_r[i] <= `LTE_THR_RST;
                tq_r[i] <= `LTE_Q_RST;
                cq_r[i] <= `LTE_Q_RST;
            end
            rdata_r <= 32'h0000_0000;
            rdy_r <= 1'b0;
            err_r <= 1'b0;
            clr_r <= 8'h00;
            lock_clr_r <= 1'b0;
        end
        else if (ce)
        begin
            recon_r <= recon_nxt;
            ext_r <= ext_nxt;
            gmask_r <= gmask_nxt;
            imask_r <= imask_nxt;
            ists_r <= ists_nxt;
            cfg_r <= cfg_nxt;
            thr_r <= thr_nxt;
            tq_r <= tq_nxt;
            cq_r <= cq_nxt;
            rdata_r <= rdata_nxt;
            rdy_r <= rdy_nxt;
            err_r <= err_nxt;
            clr_r <= clr_nxt;
            lock_clr_r <= lock_clr_nxt;
        end
    end

    // ******************************
    // protection and tick
    // ******************************
    always_comb
    begin
        tick_nxt = 1'b0;
        tick_cnt_nxt = tick_cnt_r + 8'h01;
        if (tick_cnt_r == 8'(`LTE_TICK_CYC - 1))
        begin
            tick_cnt_nxt = 8'h00;
            tick_nxt = 1'b1;
        end
        // fast lockout: a new hard trip wins over the release
        fast_nxt = (|hard_v) || (fast_r && !lock_clr_r);
        // graceful: optional self release once no fault trip remains
        if (|grace_v)
            grace_nxt = 1'b1;
        else if (recon_r || lock_clr_r)
            grace_nxt = 1'b0;
        else
            grace_nxt = grace_r;
        inv_nxt = grace_nxt || fast_nxt;
        warn_nxt = |warn_v;
        // user levels are kept out of every disconnect term above
        gpo_nxt = |(user_v & gmask_r);
        irq_nxt = |(ists_nxt & imask_r);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_r <= 8'h00;
            tick_r <= 1'b0;
            trip_d_r <= 8'h00;
            fast_r <= 1'b0;
            grace_r <= 1'b0;
            inv_r <= 1'b0;
            warn_r <= 1'b0;
            gpo_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else if (ce)
        begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r <= tick_nxt;
            trip_d_r <= tripw;
            fast_r <= fast_nxt;
            grace_r <= grace_nxt;
            inv_r <= inv_nxt;
            warn_r <= warn_nxt;
            gpo_r <= gpo_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign prdata = rdata_r;
    assign pready = rdy_r;
    assign pslverr = err_r;
    assign trip = tripw;
    assign disc_graceful = grace_r;
    assign disc_fast = fast_r;
    assign inverter_off = inv_r;
    assign derate = warn_r;
    assign gpo = gpo_r;
    assign irq = irq_r;

    // ******************************
    // checks
    // ******************************
    AST_FAST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && fast_r && !lock_clr_r) |=> fast_r)
        else $error("fast lockout released without user clear");
    AST_HARD_FAST: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && |hard_v) |=> fast_r && inv_r)
        else $error("hard fault did not disconnect");
    AST_GRACE_INV: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && |grace_v) |=> grace_r && inv_r)
        else $error("graceful fault did not disconnect");
    AST_USER_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && tripw != 8'h00 && tripw == user_v && !fast_r && !grace_r)
        |=> !fast_r && !grace_r && !warn_r)
        else $error("user trigger caused fault or warning action");
    AST_WARN_DERATE: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && |warn_v && !fast_r && !grace_r && !(|hard_v) && !(|grace_v))
        |=> warn_r && !fast_r && !grace_r)
        else $error("warning not answered by derating alone");

endmodule : lte_top

// ==== verification/lte_tb_opif.sv ====
/*
 * operator model: apb master issuing config writes, clears and reads.
 * assumes a slave that answers with pready on a rising pclk edge.
 */
`timescale 1ns/10ps
module lte_tb_opif (
    // apb master side
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // ****************************************
    // one transfer, held until pready
    // ****************************************
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed; only the bench watchdog ends a hung wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data lines must not look valid
        pwdata <= ~d;
    endtask : xfer
endmodule : lte_tb_opif

// ==== verification/tb_top.sv ====
/*
 * testbench of the limit trigger engine: scenario tasks, compares, verdict.
 * assumes lte_tb_opif as the apb operator and a 200 MHz pclk.
 */
`timescale 1ns/10ps
`include "lte_params.svh"
module tb_top;
    import lte_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    lte_meas_t meas = '0;
    logic [7:0] bits = 8'h00;
    logic [1:0] gpi = 2'h0;
    logic [7:0] trip;
    logic disc_graceful, disc_fast, inverter_off, derate, gpo, irq;
    int fail_count = 0;
    int tests_run = 0;

    always #2.5 pclk = ~pclk;

    lte_tb_opif op_u (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    lte_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
        .bits(bits), .gpi(gpi), .trip(trip), .disc_graceful(disc_graceful),
        .disc_fast(disc_fast), .inverter_off(inverter_off),
        .derate(derate), .gpo(gpo), .irq(irq));

    // ****************************************
    // helpers
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask : chk
    task wr(input logic [11:0] a, input logic [31:0] d);
        op_u.xfer(1'b1, a, d, rd, er);
    endtask : wr
    task rdc(input logic [11:0] a, input logic [31:0] exp);
        op_u.xfer(1'b0, a, 32'h0, rd, er);
        chk(rd, exp);
    endtask : rdc
    function logic [11:0] sa(input int i, input int f);
        return `LTE_A_TRIG + 12'(16 * i + 4 * f);
    endfunction : sa
    // outputs packed {trip, grace, fast, inv, derate, gpo, irq}
    task co(input int n, input logic [13:0] e);
        repeat (n) @(posedge pclk);
        #1;
        chk({18'h0, trip, disc_graceful, disc_fast, inverter_off, derate,
             gpo, irq}, {18'h0, e});
    endtask : co

    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        rdc(sa(0, 0), 32'h01);
        rdc(sa(0, 1), 32'hFFFF);
        rdc(12'h020, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("test reset done");
    endtask : t_reset
    task t_basic;
        wr(`LTE_A_IRQ_MASK, 32'h01);
        wr(sa(0, 1), 32'h0100);
        meas[0] <= 16'h0100;
        co(4, 14'h0000);
        meas[0] <= 16'h00FF;
        wr(sa(0, 0), 32'h00);
        co(3, 14'h0000);
        meas[0] <= 16'h0100;
        co(3, 14'h0045);
        meas[0] <= 16'h0000;
        co(3, 14'h0045);
        rdc(`LTE_A_IRQ_STS, 32'h01);
        co(1, 14'h0044);
        wr(`LTE_A_CLEAR, 32'h01);
        co(3, 14'h0000);
        meas[0] <= 16'h0100;
        co(3, 14'h0045);
        wr(sa(0, 0), 32'h01);
        co(2, 14'h0001);
        rdc(`LTE_A_IRQ_STS, 32'h01);
        $display("test basic done");
    endtask : t_basic
    task t_bool;
        bits[2] <= 1'b1;
        wr(sa(1, 0), 32'h5C);
        wr(sa(2, 0), 32'hA4);
        bits[1] <= 1'b1;
        co(3, 14'h00A8);
        bits[1] <= 1'b0;
        bits[2] <= 1'b0;
        co(3, 14'h01B8);
        bits[2] <= 1'b1;
        wr(`LTE_A_CLEAR, 32'h06);
        co(3, 14'h0038);
        rdc(`LTE_A_STATE, 32'h300);
        wr(`LTE_A_CLEAR, 32'h100);
        co(3, 14'h0000);
        rdc(`LTE_A_IRQ_STS, 32'h06);
        $display("test bool done");
    endtask : t_bool
    task t_hyst;
        wr(`LTE_A_GPO_MASK, 32'h08);
        wr(sa(3, 1), 32'h0200);
        wr(sa(3, 2), 32'h4);
        wr(sa(3, 0), 32'hF0);
        meas[3] <= 16'h0200;
        co(350, 14'h0000);
        meas[3] <= 16'h01FF;
        co(10, 14'h0000);
        meas[3] <= 16'h0200;
        co(350, 14'h0000);
        co(900, 14'h0202);
        rdc(`LTE_A_USER, 32'h08);
        meas[3] <= 16'h01FF;
        co(3, 14'h0000);
        wr(sa(3, 2), 32'h0);
        wr(sa(3, 0), 32'hF2);
        meas[3] <= 16'h0200;
        co(3, 14'h0202);
        meas[3] <= 16'h0000;
        co(3, 14'h0202);
        wr(`LTE_A_CLEAR, 32'h08);
        co(3, 14'h0000);
        $display("test hyst done");
    endtask : t_hyst
    task t_ext;
        wr(`LTE_A_CTRL, 32'h01);
        wr(`LTE_A_EXT, 32'h30);
        wr(sa(6, 0), 32'h7C);
        ce <= 1'b0;
        gpi <= 2'h2;
        co(3, 14'h0000);
        ce <= 1'b1;
        co(3, 14'h1028);
        gpi <= 2'h0;
        co(3, 14'h0000);
        $display("test ext done");
    endtask : t_ext

    // ****************************************
    // verdict, main sequence, watchdog
    // ****************************************
    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_basic();
        t_bool();
        t_hyst();
        t_ext();
        print_verdict();
    end
    // run is about 1800 cycles; limit well above it
    initial
    begin
        #100000;
        fail_count++;
        print_verdict();
    end
endmodule : tb_top
